// *** common/sac_map.vh ***
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

////////////////////////////////////////////////////////////////////////////
// data path
`define SAC_DATA_W        14
`define SAC_TRIAL_RST     14'h2000
`define SAC_FIFO_DEPTH    4
`define SAC_FIFO_AW       2

////////////////////////////////////////////////////////////////////////////
// conversion sequence, in conversion clocks
`define SAC_LAST_BIT_CLK  5'h0E
`define SAC_XFER_CLK      5'h0F
`define SAC_CONV_CLKS     5'h10

////////////////////////////////////////////////////////////////////////////
// timing
`define SAC_CLK_NS        4
`define SAC_CONV_NS       2200
`define SAC_INT_DIV       (`SAC_CONV_NS / (`SAC_CLK_NS * 16))
`define SAC_DIV_W         6

////////////////////////////////////////////////////////////////////////////
// pin bit positions in the synchroniser vector
`define SAC_PIN_START     0
`define SAC_PIN_EXTCLK    1
`define SAC_PIN_CS        2
`define SAC_PIN_RD        3
`define SAC_PIN_COMP      4
`define SAC_PIN_UNI       5
`define SAC_PIN_N         6

`endif

// *** rtl/sac_fifo.v ***
`timescale 1ns/1ps
module sac_fifo #(
   parameter WIDTH = 14,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock, reset and enable
   input  wire             clk_sys,
   input  wire             srst,
   input  wire             ce,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wrPtr_q;
   reg [AW:0]      rdPtr_q;

   wire full;
   wire empty;

   // extra pointer bit tells full from empty when the indices match
   assign full     = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) &&
                     (wrPtr_q[AW] != rdPtr_q[AW]);
   assign empty    = (wrPtr_q == rdPtr_q);
   assign inReady  = ~full;
   assign outValid = ~empty;
   assign outData  = mem[rdPtr_q[AW-1:0]];

   always @(posedge clk_sys) begin
      if (ce && inValid && !full) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (inValid && !full) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end

endmodule

// *** rtl/sac_conv_ctrl.v ***
// Function
// - start rising edge enters hold, starts conversion
// - status high from start until sequence ends
// - external clock high at start selects it
// - external clock low at start: internal oscillator
// - conversion takes sixteen conversion clock cycles
// - status falling returns sampler to tracking
// - result readable after end of conversion
// - data driven only with select and read low
// - internal clock conversion lasts about 2.2 us
// - bipolar results in two's complement
// - unipolar results in straight binary
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_conv_ctrl (
   // clock, reset, enable
   input  wire                   clk_sys,
   input  wire                   srst,
   input  wire                   ce,
   // pins from the host
   input  wire                   conversionStartInput,
   input  wire                   externalConversionClock,
   input  wire                   chipSelN,
   input  wire                   readN,
   // analog side and range strap
   input  wire                   compDecision,
   input  wire                   unipolarRange,
   // status and sampler
   output reg                    statusBusy,
   output reg                    holdMode,
   output reg [`SAC_DATA_W-1:0]  trialCode,
   // parallel data bus
   output reg [`SAC_DATA_W-1:0]  dataOut,
   output reg                    dataOe
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_CONV = 2'b01;
   localparam [1:0] ST_EOCP = 2'b10;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg  [`SAC_PIN_N-1:0] pinMeta_q;
   reg  [`SAC_PIN_N-1:0] pinSync_q;
   reg  [`SAC_PIN_N-1:0] pinLast_q;
   wire [`SAC_PIN_N-1:0] pinRaw;

   assign pinRaw = {unipolarRange, compDecision, readN, chipSelN,
                    externalConversionClock, conversionStartInput};

   always @(posedge clk_sys) begin
      if (srst) begin
         pinMeta_q <= 6'h0C;
         pinSync_q <= 6'h0C;
         pinLast_q <= 6'h0C;
      end else if (ce) begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
         pinLast_q <= pinSync_q;
      end
   end

   wire startS  = pinSync_q[`SAC_PIN_START];
   wire extS    = pinSync_q[`SAC_PIN_EXTCLK];
   wire csS     = pinSync_q[`SAC_PIN_CS];
   wire rdS     = pinSync_q[`SAC_PIN_RD];
   wire compS   = pinSync_q[`SAC_PIN_COMP];
   wire uniS    = pinSync_q[`SAC_PIN_UNI];

   wire startRise = startS & ~pinLast_q[`SAC_PIN_START];
   wire extFall   = ~extS & pinLast_q[`SAC_PIN_EXTCLK];
   wire rdRise    = rdS & ~pinLast_q[`SAC_PIN_RD];

   ////////////////////////////////////////////////////////////////////////
   // conversion clock

   reg  [1:0]            state_q;
   reg                   extSel_q;
   reg  [`SAC_DIV_W-1:0] divCnt_q;
   reg  [4:0]            clkCnt_q;
   reg                   unipolar_q;

   wire [31:0] divLast = `SAC_INT_DIV - 1;
   wire        intTick = (divCnt_q == divLast[`SAC_DIV_W-1:0]);
   // the end-of-conversion pulse always uses the internal period: a gated
   // external clock may already have stopped when the sequence ends
   wire        tick    = (extSel_q && state_q == ST_CONV) ? extFall
                                                          : intTick;

   always @(posedge clk_sys) begin
      if (srst) begin
         divCnt_q <= {`SAC_DIV_W{1'b0}};
      end else if (ce) begin
         if (state_q == ST_IDLE || intTick) begin
            divCnt_q <= {`SAC_DIV_W{1'b0}};
         end else begin
            divCnt_q <= divCnt_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result buffer

   wire [4:0]             clkNext = clkCnt_q + 5'h01;
   wire [3:0]             bitIdx  = 4'hE - clkNext[3:0];
   wire                   pushReady;
   wire                   pushValid;
   wire [`SAC_DATA_W-1:0] resultCode;
   wire                   headValid;
   wire [`SAC_DATA_W-1:0] headData;
   wire                   popReq;

   assign pushValid = (state_q == ST_CONV) && tick &&
                      (clkNext == `SAC_XFER_CLK);

   // bipolar: flip the msb of the offset-binary trial code
   assign resultCode = unipolar_q ? trialCode
                     : {~trialCode[`SAC_DATA_W-1],
                        trialCode[`SAC_DATA_W-2:0]};

   sac_fifo #(
      .WIDTH (`SAC_DATA_W),
      .DEPTH (`SAC_FIFO_DEPTH),
      .AW    (`SAC_FIFO_AW)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .ce       (ce),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (resultCode),
      .outValid (headValid),
      .outReady (popReq),
      .outData  (headData)
   );

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer

   always @(posedge clk_sys) begin
      if (srst) begin
         state_q    <= ST_IDLE;
         extSel_q   <= 1'b0;
         clkCnt_q   <= 5'h00;
         unipolar_q <= 1'b0;
         statusBusy <= 1'b0;
         holdMode   <= 1'b0;
         trialCode  <= `SAC_TRIAL_RST;
      end else if (ce) begin
         case (state_q)
            ST_IDLE: begin
               if (startRise) begin
                  state_q    <= ST_CONV;
                  holdMode   <= 1'b1;
                  statusBusy <= 1'b1;
                  extSel_q   <= extS;
                  unipolar_q <= uniS;
                  clkCnt_q   <= 5'h00;
                  trialCode  <= `SAC_TRIAL_RST;
               end
            end
            ST_CONV: begin
               // starts that arrive mid-conversion are ignored
               if (tick) begin
                  if (clkNext <= `SAC_LAST_BIT_CLK) begin
                     trialCode[bitIdx] <= compS;
                     if (bitIdx != 4'h0) begin
                        trialCode[bitIdx-4'h1] <= 1'b1;
                     end
                     clkCnt_q <= clkNext;
                  end else if (clkNext == `SAC_XFER_CLK) begin
                     // a full buffer stalls here until a read frees a
                     // slot; that tick is retried on the next one
                     if (pushReady) begin
                        clkCnt_q <= clkNext;
                     end
                  end else begin
                     clkCnt_q   <= 5'h00;
                     holdMode   <= 1'b0;
                     statusBusy <= 1'b0;
                     if (startS) begin
                        state_q <= ST_EOCP;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
            end
            ST_EOCP: begin
               // start high at the end: status low until the next internal tick (one full period in internal mode)
               if (tick) begin
                  statusBusy <= 1'b1;
                  state_q    <= ST_IDLE;
               end
            end
            default: begin
               state_q    <= ST_IDLE;
               statusBusy <= 1'b0;
               holdMode   <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // parallel read port

   wire readEn = ~csS & ~rdS;

   // a word leaves the buffer when the read strobe ends under select
   assign popReq = rdRise & ~csS;

   always @(posedge clk_sys) begin
      if (srst) begin
         dataOe  <= 1'b0;
         dataOut <= {`SAC_DATA_W{1'b0}};
      end else if (ce) begin
         dataOe <= readEn;
         // freeze the word while it is on the bus so it cannot tear
         if (headValid && !readEn) begin
            dataOut <= headData;
         end
      end
   end

endmodule

// *** tb/sac_analog_model.sv ***
`timescale 1ns/1ps
// comparator behind the sampler; a held level at or above the
// trial code keeps the bit, so a conversion ends on the level itself
module sac_analog_model (
   // held level, offset binary
   input  wire logic [13:0] target,
   // trial code and decision
   input  wire logic [13:0] trialCode,
   output logic             compDecision
);
   assign compDecision = (target >= trialCode);
endmodule

// *** tb/sac_conv_ctrl_assertions.sv ***
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_conv_ctrl_assertions (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // host pins
   input  wire logic        conversionStartInput,
   input  wire logic        externalConversionClock,
   input  wire logic        chipSelN,
   input  wire logic        readN,
   // outputs
   input  wire logic        statusBusy,
   input  wire logic        holdMode,
   input  wire logic [13:0] trialCode,
   input  wire logic [13:0] dataOut,
   input  wire logic        dataOe
);
   logic [11:0] busyCnt_q;
   logic [4:0]  extFalls_q;
   logic        extSel_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////
   // clock source is known only once busy rises
   always @(posedge clk_sys) begin
      busyCnt_q <= statusBusy ? busyCnt_q + 12'h001 : 12'h000;
      if (!statusBusy) begin
         extFalls_q <= 5'h00;
      end else if ($fell(externalConversionClock)) begin
         extFalls_q <= extFalls_q + 5'h01;
      end
      if ($rose(statusBusy)) begin
         extSel_q <= externalConversionClock;
      end
   end
   start_busy_a: assert property (
      $rose(conversionStartInput) && !statusBusy && !holdMode |->
      ##[2:5] (statusBusy && holdMode && trialCode == `SAC_TRIAL_RST))
      else $error("start edge did not begin a conversion");
   // busy may already stand high after a pulsed end, so check its level
   hold_rise_a: assert property ($rose(holdMode) |-> statusBusy &&
      trialCode == `SAC_TRIAL_RST)
      else $error("hold entered apart from busy");
   track_idle_a: assert property (!statusBusy |-> !holdMode)
      else $error("sampler holding while not busy");
   oe_on_a: assert property (
      (!chipSelN && !readN) [*6] |-> dataOe)
      else $error("data bus not driven during read");
   oe_off_a: assert property (
      (chipSelN || readN) [*4] |=> !dataOe)
      else $error("data bus driven without read");
   data_hold_a: assert property (
      dataOe && $past(dataOe) |-> $stable(dataOut))
      else $error("read data changed while driven");
   int_len_a: assert property (
      $fell(statusBusy) && !extSel_q |-> busyCnt_q >= 12'h21C)
      else $error("internal conversion too short");
   ext_len_a: assert property (
      $fell(statusBusy) && extSel_q |-> extFalls_q == 5'h10)
      else $error("external conversion clock count wrong");
   cover property ($fell(statusBusy) && extSel_q);
   cover property ($fell(statusBusy) && !extSel_q);
   cover property ($rose(dataOe));
   cover property ($rose(statusBusy) && !holdMode);
endmodule

// *** tb/sac_conv_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module sac_conv_ctrl_tb_top;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        convStart = 1'b0;
   logic        extClk = 1'b0;
   logic        chipSelN = 1'b1;
   logic        readN = 1'b1;
   logic        unipolar = 1'b0;
   logic [13:0] target = 14'h0000;
   logic [13:0] lastWord;
   logic [13:0] frozen;
   logic        ce = 1'b1;
   wire         comp, busy, hold, oe;
   wire  [13:0] trial, dout;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          expQ[$];
   always #2 clk_sys = ~clk_sys;
   sac_analog_model sac_analog_model_inst (.target(target),
      .trialCode(trial), .compDecision(comp));
   sac_conv_ctrl sac_conv_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
      .ce(ce), .conversionStartInput(convStart),
      .externalConversionClock(extClk), .chipSelN(chipSelN),
      .readN(readN), .compDecision(comp), .unipolarRange(unipolar),
      .statusBusy(busy), .holdMode(hold), .trialCode(trial),
      .dataOut(dout), .dataOe(oe));
   ////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [13:0] got, input logic [13:0] e);
      total_checks++;
      if (got !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   task automatic waitBusy(input logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 1500) begin
         @(negedge clk_sys);
         k++;
      end
      check({13'h0, busy}, {13'h0, lvl});
   endtask
   // start pin falls again before the end, so busy stays low after
   task automatic startConv(input logic ext);
      target = 14'($urandom);
      unipolar = 1'($urandom);
      extClk = ext;
      // new level must settle and the bus stay quiet before the edge
      repeat (80) @(negedge clk_sys);
      convStart = 1'b1;
      repeat (4) @(negedge clk_sys);
      convStart = 1'b0;
      waitBusy(1'b1);
      check({13'h0, hold}, 14'h0001);
      if (ext) begin
         repeat (30) @(negedge clk_sys);
         repeat (16) begin
            extClk = 1'b0;
            repeat (4) @(negedge clk_sys);
            extClk = 1'b1;
            repeat (4) @(negedge clk_sys);
         end
      end
   endtask
   task automatic finishConv;
      waitBusy(1'b0);
      check({13'h0, hold}, 14'h0000);
      expQ.push_back(unipolar ? target : target ^ 14'h2000);
      repeat (80) @(negedge clk_sys);
   endtask
   // select is dropped after the strobe so the strobe edge pops
   task automatic readWord(input logic [13:0] e);
      chipSelN = 1'b0;
      readN = 1'b0;
      repeat (6) @(negedge clk_sys);
      check({13'h0, oe}, 14'h0001);
      check(dout, e);
      readN = 1'b1;
      repeat (4) @(negedge clk_sys);
      chipSelN = 1'b1;
      repeat (4) @(negedge clk_sys);
      check({13'h0, oe}, 14'h0000);
      lastWord = e;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hDE1B));
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      check({13'h0, busy}, 14'h0000);
      check({13'h0, oe}, 14'h0000);
      for (int i = 0; i < 4; i++) begin
         startConv(1'b0);
         if (i == 1) begin
            // enable low mid-conversion: the whole sequence must freeze
            frozen = trial;
            ce = 1'b0;
            repeat (50) @(negedge clk_sys);
            check(trial, frozen);
            check({13'h0, busy}, 14'h0001);
            ce = 1'b1;
         end
         finishConv();
      end
      // fifo full: the fifth result waits for a pop
      startConv(1'b0);
      repeat (700) @(negedge clk_sys);
      check({13'h0, busy}, 14'h0001);
      readWord(14'(expQ.pop_front()));
      finishConv();
      while (expQ.size() > 0)
         readWord(14'(expQ.pop_front()));
      readWord(lastWord);
      startConv(1'b1);
      finishConv();
      readWord(14'(expQ.pop_front()));
      // start raised again and held to the end: pulsed end of conversion
      startConv(1'b0);
      @(negedge clk_sys);
      convStart = 1'b1;
      finishConv();
      check({13'h0, busy}, 14'h0001);
      readWord(14'(expQ.pop_front()));
      summarize();
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
   end
endmodule
bind sac_conv_ctrl sac_conv_ctrl_assertions sac_conv_ctrl_assertions_inst (
   .clk_sys(clk_sys), .srst(srst),
   .conversionStartInput(conversionStartInput),
   .externalConversionClock(externalConversionClock),
   .chipSelN(chipSelN), .readN(readN), .statusBusy(statusBusy),
   .holdMode(holdMode), .trialCode(trialCode), .dataOut(dataOut),
   .dataOe(dataOe));
